// *** dv/parallel_io_handshake_port_test.sv ***
// Bench for the device and host pair, driven over the host's AHB-Lite port.
// Assumes a zero-wait host; the host also plays the peripheral's pins.
`timescale 1ns/1ps
module parallel_io_handshake_port_test;
  // ****************************************
  // Signals, instances and tasks
  // ****************************************
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [31:0] r;
  int          bad_count;
  int          check_count;
  logic [1:0]  cs = 2'h2;
  logic [15:0] ops [3] = '{16'h63C5, 16'h400A, 16'h50C0};
  logic [11:0] exps [3] = '{12'h3C5, 12'h3CF, 12'h30F};
  logic [11:0] bad_sel [2] = '{12'h040, 12'h008};
  pioh_if      io ();
  pioh_device i_pioh_device (.hclk(hclk), .hresetn(hresetn), .chip_select_bit_a(cs[0]), .chip_select_bit_b(cs[1]),
    .io(io.device));
  pioh_host i_pioh_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .hwrite(hwrite),
    .htrans(htrans), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .io(io.host));
  pioh_chk i_pioh_chk (.hclk(hclk), .hresetn(hresetn), .chip_select_bit_a(cs[0]), .chip_select_bit_b(cs[1]),
    .system_bus(io.system_bus), .address_latch_strobe(io.address_latch_strobe),
    .device_select_strobe_n(io.device_select_strobe_n), .input_transfer_oe(io.input_transfer_oe),
    .skip_or_irq_out_n(io.skip_or_irq_out_n), .pa(io.pa), .pa_dev_oe(io.pa_dev_oe),
    .pb_dev_o(io.pb_dev_o), .pb_dev_oe(io.pb_dev_oe));
  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Next edge with hready high; a stuck bus ends the run
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (hreadyout !== 1'h1) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  // One instruction; x flips command bits to make it foreign. Status ends in r
  task automatic io_transfer_instruction(input logic [3:0] c, input logic [11:0] acc, input logic [11:0] x);
    int n;
    n = 0;
    ahb(1'h1, pioh_pkg::HOST_ACC_OFS, {20'h00000, acc});
    ahb(1'h1, pioh_pkg::HOST_CMD_OFS, {20'h00000, {c[0], c[1], c[2], c[3], 8'hB3} ^ x});
    do begin
      ahb(1'h0, pioh_pkg::HOST_STAT_OFS, 32'h00000000);
      n++;
    end while (r[12] !== 1'h0 && n < 200);
    if (r[12] !== 1'h0) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  task automatic pins;
    ahb(1'h0, pioh_pkg::HOST_PIN_OFS, 32'h00000000);
  endtask
  initial begin
    hresetn = 1'h0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwrite = 1'h0;
    hwdata = 32'h00000000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    io_transfer_instruction(4'hF, 12'h000, 12'h000);
    chk("reset status", 32'h100, r[11:0]);
    io_transfer_instruction(4'h2, 12'hA50, 12'h000);
    pins;
    chk("eight bit port a", 32'h5A, r[19:12]);
    foreach (ops[i]) begin
      io_transfer_instruction(ops[i][15:12], ops[i][11:0], 12'h000);
      pins;
      chk("port b op", exps[i], r[11:0]);
    end
    foreach (bad_sel[i]) begin
      io_transfer_instruction(4'h6, 12'hFFF, bad_sel[i]);
      pins;
      chk("foreign command", 32'h30F, r[11:0]);
    end
    for (int k = 0; k < 4; k++) begin
      if (k == 2) io_transfer_instruction(4'h2, 12'h000, 12'h000);
      io_transfer_instruction(4'hC + 4'(k % 2), 12'h000, 12'h000);
      chk("skip seen", 32'(k / 2), r[13]);
    end
    io_transfer_instruction(4'hE, 12'h300, 12'h000);
    io_transfer_instruction(4'hA, 12'h900, 12'h000);
    pins;
    chk("three port c", 32'h90, r[19:12]);
    io_transfer_instruction(4'h7, 12'h000, 12'h000);
    ahb(1'h1, pioh_pkg::HOST_PDATA_OFS, 32'h15A5);
    io_transfer_instruction(4'h7, 12'h00F, 12'h000);
    chk("read merge", 32'h15AF, {r[14], r[11:0]});
    ahb(1'h1, pioh_pkg::HOST_PDATA_OFS, 32'h0);
    $display("test plain modes done");
    io_transfer_instruction(4'hE, 12'h000, 12'h000);
    io_transfer_instruction(4'h2, 12'h600, 12'h000);
    io_transfer_instruction(4'hF, 12'h000, 12'h000);
    chk("handshake status", 32'h1800, {r[15], r[11:0]});
    io_transfer_instruction(4'h6, 12'h123, 12'h000);
    pins;
    chk("full no strobe", 32'hA000, r[15:0]);
    ahb(1'h1, pioh_pkg::HOST_PCTL_OFS, 32'h44);
    pins;
    chk("strobe high", 32'hE123, r[15:0]);
    ahb(1'h1, pioh_pkg::HOST_PCTL_OFS, 32'h40);
    repeat (2) pins;
    chk("strobe fall", 32'h2000, r[15:0]);
    ahb(1'h1, pioh_pkg::HOST_PDATA_OFS, 32'h1ABC);
    ahb(1'h1, pioh_pkg::HOST_PCTL_OFS, 32'h51);
    ahb(1'h1, pioh_pkg::HOST_PCTL_OFS, 32'h50);
    repeat (2) pins;
    chk("input latched", 32'h0ABC, r[15:0]);
    ahb(1'h1, pioh_pkg::HOST_PDATA_OFS, 32'h0);
    io_transfer_instruction(4'h7, 12'h000, 12'h000);
    chk("input word", 32'hABC, r[11:0]);
    pins;
    chk("empty again", 32'h2, r[15:12]);
    $display("test handshake done");
    report_and_stop;
  end
endmodule

// *** dv/pioh_chk.sv ***
// Pin checker for the device and host ends of the parallel port.
// Assumes one clock and straps fed with the device's own values.
`timescale 1ns/1ps
module pioh_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        chip_select_bit_a,
  input wire logic        chip_select_bit_b,
  input wire logic [11:0] system_bus,
  input wire logic        address_latch_strobe,
  input wire logic        device_select_strobe_n,
  input wire logic        input_transfer_oe,
  input wire logic        skip_or_irq_out_n,
  input wire logic [11:8] pa,
  input wire logic [11:8] pa_dev_oe,
  input wire logic [11:0] pb_dev_o,
  input wire logic [11:0] pb_dev_oe
);
  // ****************************************
  // Helper state and properties
  // ****************************************
  logic [11:0] cmd_q;
  logic [11:0] acc_q;
  logic        wr_q;
  wire         hs_w = pa_dev_oe == pioh_pkg::HS_DRIVEN_LINES;
  wire         ok_w = cmd_q[7:3] == {chip_select_bit_b, chip_select_bit_a, 3'h6};
  wire         pbop_w = !cmd_q[8] && cmd_q[9] && !(cmd_q[10] && cmd_q[11]);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mirror of the latched command; wr_q marks that the next select rise is the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 12'h000;
      acc_q <= 12'h000;
      wr_q  <= 1'h0;
    end else begin
      if ($fell(address_latch_strobe)) cmd_q <= system_bus;
      if ($rose(device_select_strobe_n)) acc_q <= system_bus;
      if ($fell(address_latch_strobe) || $rose(device_select_strobe_n)) wr_q <= $rose(device_select_strobe_n);
    end
  end
  property p_xfer; input_transfer_oe |-> !device_select_strobe_n; endproperty
  a_xfer: assert property (p_xfer) else $error("transfer line low outside select");
  property p_sel; input_transfer_oe |-> ok_w; endproperty
  a_sel: assert property (p_sel) else $error("answered a foreign command");
  property p_oe; hs_w && pb_dev_oe != 12'h000 |-> pa[10]; endproperty
  a_oe: assert property (p_oe) else $error("port b driven without output strobe");
  property p_ofall; hs_w && $fell(pa[10]) |-> pb_dev_oe == 12'h000 ##1 !pa[11]; endproperty
  a_ofall: assert property (p_ofall) else $error("output strobe fall mishandled");
  property p_ifall; hs_w && $fell(pa[8]) |=> !pa[9]; endproperty
  a_ifall: assert property (p_ifall) else $error("empty flag stayed high");
  property p_irq;
    device_select_strobe_n && $past(device_select_strobe_n, 2) && !skip_or_irq_out_n
      |-> $past(pa_dev_oe) == pioh_pkg::HS_DRIVEN_LINES;
  endproperty
  a_irq: assert property (p_irq) else $error("irq outside handshake mode");
  property p_full; hs_w && ok_w && pbop_w && wr_q && $rose(device_select_strobe_n) |-> ##[1:2] pa[11]; endproperty
  a_full: assert property (p_full) else $error("full flag not raised");
  property p_wpb;
    !hs_w && ok_w && wr_q && $rose(device_select_strobe_n) && cmd_q[11:8] == 4'h6
      |-> ##[1:2] pb_dev_o == acc_q && pb_dev_oe == 12'hFFF;
  endproperty
  a_wpb: assert property (p_wpb) else $error("port b write not applied");
  c_wr: cover property (wr_q && $rose(device_select_strobe_n));
  c_irq: cover property (hs_w && !skip_or_irq_out_n);
  c_pbo: cover property (hs_w && pb_dev_oe != 12'h000);
endmodule

// *** src/pioh_device.sv ***
// Twenty-line parallel port with handshake mode, seen from the system bus.
// Assumes strobes and pins are synchronous to hclk; edges found by sampling.
`timescale 1ns/1ps
module pioh_device (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic chip_select_bit_a,
  input  wire logic chip_select_bit_b,
  pioh_if.device    io
);
  // ****************************************
  // Helpers
  // ****************************************
  // Set, clear or copy of the accumulator into a port value
  function automatic logic [11:0] apply_op(input logic [1:0] op, input logic [11:0] old,
                                           input logic [11:0] acc);
    case (op)
      pioh_pkg::OPK_SET:   apply_op = old | acc;
      pioh_pkg::OPK_CLEAR: apply_op = old & ~acc;
      pioh_pkg::OPK_WRITE: apply_op = acc;
      default:             apply_op = old;
    endcase
  endfunction

  // ****************************************
  // Strobe edges and command capture
  // ****************************************
  logic        als_q;
  logic        dss_q;
  logic        irs_q;
  logic        ors_q;
  logic        sel_q;
  logic        pulse_q;
  logic [3:0]  ctl_q;
  logic [11:0] bus;
  logic        als_fall;
  logic        dss_rise;
  logic        irs_fall;
  logic        ors_fall;
  logic        hit;

  assign bus      = io.system_bus;
  assign als_fall = als_q & ~io.address_latch_strobe;
  assign dss_rise = ~dss_q & io.device_select_strobe_n;
  assign irs_fall = irs_q & ~io.pa[pioh_pkg::LN_IN_STROBE];
  assign ors_fall = ors_q & ~io.pa[pioh_pkg::LN_OUT_STROBE];
  // Bits 3-5 read in bus order against the fixed pattern
  assign hit = ({bus[3], bus[4], bus[5]} == pioh_pkg::DEV_PATTERN) &
               (bus[pioh_pkg::CS_A_POS] == chip_select_bit_a) &
               (bus[pioh_pkg::CS_B_POS] == chip_select_bit_b);

  // Previous strobe levels for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      als_q <= 1'b0;
      dss_q <= 1'b1;
      irs_q <= 1'b0;
      ors_q <= 1'b0;
    end else begin
      als_q <= io.address_latch_strobe;
      dss_q <= io.device_select_strobe_n;
      irs_q <= io.pa[pioh_pkg::LN_IN_STROBE];
      ors_q <= io.pa[pioh_pkg::LN_OUT_STROBE];
    end
  end

  // Command latch; first select pulse is the read, the next the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q   <= 1'b0;
      pulse_q <= 1'b0;
      ctl_q   <= 4'h0;
    end else if (als_fall) begin
      sel_q   <= hit;
      pulse_q <= 1'b0;
      ctl_q   <= {bus[8], bus[9], bus[10], bus[11]};
    end else if (sel_q && dss_rise) begin
      pulse_q <= 1'b1;
      sel_q   <= ~pulse_q;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  logic        m8_q;
  logic        m9_q;
  logic [11:8] hs_q;
  logic [11:4] pa_out_q;
  logic [11:8] pc_out_q;
  logic [11:0] pb_out_q;
  logic        pa_dir_q;
  logic        pb_dir_q;
  logic        pc_dir_q;
  logic [11:4] pa_in_q;
  logic [11:8] pc_in_q;
  logic [11:0] pb_in_q;
  logic [1:0]  port;
  logic [1:0]  op;
  logic        hs_mode;
  logic        wide_a;
  logic        rd_act;
  logic        rd_done;
  logic        wr_done;
  logic        is_read;
  logic        is_skip;
  logic        wr_port;
  logic        irq_out;
  logic        irq_in;
  logic        skip_cond;
  logic [11:0] acc;
  logic [11:0] rd_word;
  logic [11:0] pa_view;
  logic [11:0] st_word;

  assign port    = ctl_q[3:2];
  assign op      = ctl_q[1:0];
  assign acc     = bus;
  assign hs_mode = ~m8_q;
  assign wide_a  = m8_q & ~m9_q;
  assign rd_act  = sel_q & ~pulse_q & ~io.device_select_strobe_n;
  assign rd_done = sel_q & ~pulse_q & dss_rise;
  assign wr_done = sel_q & pulse_q & dss_rise;
  assign is_read = ((op == pioh_pkg::OPK_READ) && (port != 2'h3)) || (ctl_q == pioh_pkg::READ_STATUS_CMD);
  assign is_skip = (ctl_q == pioh_pkg::SKIP_ON_OUTPUT_CMD) || (ctl_q == pioh_pkg::SKIP_ON_INPUT_CMD);
  assign wr_port = wr_done & (op != pioh_pkg::OPK_READ) & (port != 2'h3);
  // Level requests, withdrawn by flag high, enable low or mode change
  assign irq_out = hs_mode & hs_q[10] & ~hs_q[pioh_pkg::LN_OUT_FULL];
  assign irq_in  = hs_mode & hs_q[8] & ~hs_q[pioh_pkg::LN_IN_EMPTY];
  // Skip means the tested line is low
  assign skip_cond = (ctl_q == pioh_pkg::SKIP_ON_OUTPUT_CMD) ?
                     ~(hs_mode ? hs_q[pioh_pkg::LN_OUT_FULL] : io.pa[11]) :
                     ~(hs_mode ? hs_q[pioh_pkg::LN_IN_EMPTY] : io.pa[9]);

  // Read views of port A and status
  assign pa_view = hs_mode ? {hs_q[11], io.pa[10], hs_q[9], io.pa[8], 8'h00} :
                   wide_a  ? {pa_in_q, 4'h0} : {pa_in_q[11:8], 8'h00};
  assign st_word = {hs_mode ? {~irq_in, ~irq_out} : {io.pa[9], io.pa[11]},
                    m9_q, m8_q, 8'h00};
  assign rd_word = (ctl_q == pioh_pkg::READ_STATUS_CMD) ? st_word :
                   (port == pioh_pkg::PORT_A) ? pa_view :
                   (port == pioh_pkg::PORT_B) ? pb_in_q :
                   (port == pioh_pkg::PORT_C && !wide_a) ? {pc_in_q, 8'h00} : 12'h000;

  // ****************************************
  // Mode, handshake flags and enables
  // ****************************************
  logic [11:8] hs_d;
  logic        hs_wr_a;
  logic        hs_wr_b;
  logic [11:0] hs_op;

  assign hs_wr_a = wr_port & hs_mode & (port == pioh_pkg::PORT_A);
  assign hs_wr_b = wr_port & hs_mode & (port == pioh_pkg::PORT_B);
  assign hs_op   = apply_op(op, {hs_q, 8'h00}, acc);
  // Later lines win: strobe events override a port A flag write; a port B write beats the output strobe fall
  always_comb begin
    hs_d = hs_q;
    if (hs_wr_a)
      hs_d = hs_op[11:8];
    if (hs_mode && ors_fall)
      hs_d[pioh_pkg::LN_OUT_FULL] = 1'b0;
    if (hs_wr_b)
      hs_d[pioh_pkg::LN_OUT_FULL] = 1'b1;
    if (hs_mode && rd_done && ctl_q == pioh_pkg::READ_PORT_B_CMD)
      hs_d[pioh_pkg::LN_IN_EMPTY] = 1'b1;
    if (hs_mode && irs_fall)
      hs_d[pioh_pkg::LN_IN_EMPTY] = 1'b0;
  end

  // Flags update the cycle after the event, so the full flag trails
  // the port B tristate at the output strobe fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= 4'h0;
      m8_q <= pioh_pkg::MODE_HI_RST;
      m9_q <= pioh_pkg::MODE_LO_RST;
    end else begin
      hs_q <= hs_d;
      if (wr_done && ctl_q == pioh_pkg::WRITE_STATUS_CMD) begin
        m8_q <= acc[pioh_pkg::ST_MODE_HI];
        m9_q <= acc[pioh_pkg::ST_MODE_LO];
      end
    end
  end

  // ****************************************
  // Port latches and directions
  // ****************************************
  logic [11:0] pa_mask;
  logic        rd_port;
  logic [11:0] pa_op;
  logic [11:0] pc_op;

  assign pa_mask = wide_a ? 12'hFF0 : 12'hF00;
  assign pa_op   = apply_op(op, {pa_out_q, 4'h0}, acc & pa_mask) & pa_mask;
  assign pc_op   = apply_op(op, {pc_out_q, 8'h00}, acc);
  assign rd_port = rd_done & (op == pioh_pkg::OPK_READ) & (port != 2'h3);

  // Output latches and direction bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_out_q <= 8'h00;
      pb_out_q <= 12'h000;
      pc_out_q <= 4'h0;
      pa_dir_q <= pioh_pkg::DIR_RST;
      pb_dir_q <= pioh_pkg::DIR_RST;
      pc_dir_q <= pioh_pkg::DIR_RST;
    end else begin
      if (wr_port && port == pioh_pkg::PORT_A && !hs_mode) begin
        pa_out_q <= pa_op[11:4] | (pa_out_q & ~pa_mask[11:4]);
        pa_dir_q <= 1'b1;
      end
      if (wr_port && port == pioh_pkg::PORT_B) begin
        pb_out_q <= apply_op(op, pb_out_q, acc);
        pb_dir_q <= 1'b1;
      end
      if (wr_port && port == pioh_pkg::PORT_C && !wide_a) begin
        pc_out_q <= pc_op[11:8];
        pc_dir_q <= 1'b1;
      end
      if (rd_port && port == pioh_pkg::PORT_A)
        pa_dir_q <= 1'b0;
      if (rd_port && port == pioh_pkg::PORT_B)
        pb_dir_q <= 1'b0;
      if (rd_port && port == pioh_pkg::PORT_C && !wide_a)
        pc_dir_q <= 1'b0;
    end
  end

  // Input latches: every address strobe, port B by input strobe in handshake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_in_q <= 8'h00;
      pc_in_q <= 4'h0;
      pb_in_q <= 12'h000;
    end else begin
      if (als_fall) begin
        pa_in_q <= {io.pa, io.pc};
        pc_in_q <= io.pc;
      end
      if (hs_mode ? irs_fall : als_fall)
        pb_in_q <= io.pb;
    end
  end

  // ****************************************
  // Bus side answers
  // ****************************************
  logic [11:0] bus_q;
  logic        skp_n_q;

  // Registered read data and shared skip/irq line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q   <= 12'h000;
      skp_n_q <= 1'b1;
    end else begin
      bus_q   <= rd_word;
      skp_n_q <= (rd_act && is_skip) ? ~skip_cond : ~(irq_out | irq_in);
    end
  end

  assign io.bus_dev_o         = bus_q;
  assign io.bus_dev_oe        = rd_act & is_read;
  assign io.input_transfer_oe = rd_act & is_read;
  assign io.skip_or_irq_out_n = skp_n_q;

  // ****************************************
  // Pin drivers per mode
  // ****************************************
  // Handshake: lines 9 and 11 carry flags, 8 and 10 are strobe inputs
  assign io.pa_dev_o  = hs_mode ? (hs_q & pioh_pkg::HS_DRIVEN_LINES) : pa_out_q[11:8];
  assign io.pa_dev_oe = hs_mode ? pioh_pkg::HS_DRIVEN_LINES : {4{pa_dir_q}};
  // In eight-bit-A mode the C pins carry port A lines 4-7
  assign io.pc_dev_o  = wide_a ? pa_out_q[7:4] : pc_out_q;
  assign io.pc_dev_oe = wide_a ? {4{pa_dir_q}} : {4{pc_dir_q}};
  assign io.pb_dev_o  = pb_out_q;
  assign io.pb_dev_oe = hs_mode ? {12{io.pa[pioh_pkg::LN_OUT_STROBE]}} : {12{pb_dir_q}};
endmodule

// *** src/pioh_host.sv ***
// Processor-side end: runs one I/O transfer cycle per software command and
// plays the peripheral's pins. Software reaches it over AHB-Lite, zero wait.
`timescale 1ns/1ps
module pioh_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic        hwrite,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  pioh_if.host             io
);
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_LATCH, H_READ, H_GAP, H_WRITE, H_HOLD} pioh_state_e;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  pioh_state_e state_q;
  logic [7:0]  addr_q;
  logic        wph_q;
  logic [31:0] rdat_q;
  logic [11:0] cmd_q;
  logic [11:0] acc_q;
  logic [11:0] res_q;
  logic        skip_q;
  logic        c1_q;
  logic [15:0] pctl_q;
  logic [12:0] pdat_q;
  logic [4:0]  cnt_q;
  logic        take;
  logic        busy;
  logic        wr_cmd;
  logic [31:0] rd_mux;
  logic        last;

  assign take   = hsel & hready & htrans[1];
  assign busy   = (state_q != H_IDLE);
  assign wr_cmd = wph_q & (addr_q == pioh_pkg::HOST_CMD_OFS) & ~busy;
  assign rd_mux = (haddr[7:0] == pioh_pkg::HOST_ACC_OFS)   ? {20'h0, acc_q} :
                  (haddr[7:0] == pioh_pkg::HOST_STAT_OFS)  ?
                    {16'h0, ~io.skip_or_irq_out_n & ~busy, c1_q, skip_q, busy, res_q} :
                  (haddr[7:0] == pioh_pkg::HOST_PCTL_OFS)  ? {16'h0, pctl_q} :
                  (haddr[7:0] == pioh_pkg::HOST_PDATA_OFS) ? {19'h0, pdat_q} :
                  (haddr[7:0] == pioh_pkg::HOST_PIN_OFS)   ? {12'h0, io.pc, io.pa, io.pb} :
                  (haddr[7:0] == pioh_pkg::HOST_CMD_OFS)   ? {20'h0, cmd_q} : 32'h0;
  assign hrdata    = rdat_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture; read data is registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wph_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      wph_q <= take & hwrite;
      if (take)
        addr_q <= haddr[7:0];
      if (take && !hwrite)
        rdat_q <= rd_mux;
    end
  end

  // Register writes; a command written while busy is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q  <= 12'h000;
      acc_q  <= 12'h000;
      pctl_q <= 16'h0000;
      pdat_q <= 13'h0000;
    end else if (wph_q) begin
      if (wr_cmd)
        cmd_q <= hwdata[11:0];
      if (addr_q == pioh_pkg::HOST_ACC_OFS && !busy)
        acc_q <= hwdata[11:0];
      if (addr_q == pioh_pkg::HOST_PCTL_OFS)
        pctl_q <= hwdata[15:0];
      if (addr_q == pioh_pkg::HOST_PDATA_OFS)
        pdat_q <= hwdata[12:0];
    end
  end

  // ****************************************
  // Transfer cycle sequencer
  // ****************************************
  assign last = (cnt_q == pioh_pkg::PHASE_CYC - 5'd1);

  // Each phase lasts a fixed count; read answers sampled in its last cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= H_IDLE;
      cnt_q   <= 5'd0;
      res_q   <= 12'h000;
      skip_q  <= 1'b0;
      c1_q    <= 1'b0;
    end else begin
      cnt_q <= (state_q == H_IDLE || last) ? 5'd0 : cnt_q + 5'd1;
      case (state_q)
        H_IDLE:  if (wr_cmd) state_q <= H_ADDR;
        H_ADDR:  if (last) state_q <= H_LATCH;
        H_LATCH: if (last) state_q <= H_READ;
        H_READ: begin
          if (last) begin
            state_q <= H_GAP;
            res_q   <= acc_q | (io.input_transfer_out_n ? 12'h000 : io.system_bus);
            skip_q  <= ~io.skip_or_irq_out_n;
            c1_q    <= ~io.input_transfer_out_n;
          end
        end
        H_GAP:   if (last) state_q <= H_WRITE;
        H_WRITE: if (last) state_q <= H_HOLD;
        H_HOLD:  if (last) state_q <= H_IDLE;
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // Bus pins: address word, then read pulse, then write pulse with data held
  assign io.address_latch_strobe   = (state_q == H_ADDR);
  assign io.device_select_strobe_n = ~(state_q == H_READ || state_q == H_WRITE);
  assign io.bus_host_oe = (state_q == H_ADDR) | (state_q == H_LATCH) |
                          (state_q == H_WRITE) | (state_q == H_HOLD);
  assign io.bus_host_o  = (state_q == H_ADDR || state_q == H_LATCH) ? cmd_q : acc_q;

  // Peripheral pins follow software directly
  assign io.pa_per_o  = pctl_q[3:0];
  assign io.pa_per_oe = pctl_q[7:4];
  assign io.pc_per_o  = pctl_q[11:8];
  assign io.pc_per_oe = pctl_q[15:12];
  assign io.pb_per_o  = pdat_q[11:0];
  assign io.pb_per_oe = {12{pdat_q[12]}};
endmodule

// *** src/pioh_if.sv ***
// Pin bundle between the parallel port device and the processor/peripheral end.
// Each shared line is resolved here from the drivers' data and enables.
`timescale 1ns/1ps
interface pioh_if;
  logic [11:0] bus_host_o;
  logic        bus_host_oe;
  logic [11:0] bus_dev_o;
  logic        bus_dev_oe;
  logic        address_latch_strobe;
  logic        device_select_strobe_n;
  logic        input_transfer_oe;
  logic        skip_or_irq_out_n;
  logic [11:8] pa_dev_o;
  logic [11:8] pa_dev_oe;
  logic [11:8] pa_per_o;
  logic [11:8] pa_per_oe;
  logic [11:8] pc_dev_o;
  logic [11:8] pc_dev_oe;
  logic [11:8] pc_per_o;
  logic [11:8] pc_per_oe;
  logic [11:0] pb_dev_o;
  logic [11:0] pb_dev_oe;
  logic [11:0] pb_per_o;
  logic [11:0] pb_per_oe;
  logic [11:0] system_bus;
  logic [11:8] pa;
  logic [11:8] pc;
  logic [11:0] pb;
  logic        input_transfer_out_n;

  // Wired resolution: undriven lines read low
  assign system_bus = (bus_dev_o & {12{bus_dev_oe}}) | (bus_host_o & {12{bus_host_oe}});
  assign pa = (pa_dev_o & pa_dev_oe) | (pa_per_o & pa_per_oe);
  assign pc = (pc_dev_o & pc_dev_oe) | (pc_per_o & pc_per_oe);
  assign pb = (pb_dev_o & pb_dev_oe) | (pb_per_o & pb_per_oe);
  assign input_transfer_out_n = ~input_transfer_oe;

  modport device (
    input  system_bus, address_latch_strobe, device_select_strobe_n, pa, pc, pb,
    output bus_dev_o, bus_dev_oe, input_transfer_oe, skip_or_irq_out_n,
    output pa_dev_o, pa_dev_oe, pc_dev_o, pc_dev_oe, pb_dev_o, pb_dev_oe
  );
  modport host (
    input  system_bus, input_transfer_out_n, skip_or_irq_out_n, pa, pc, pb,
    output bus_host_o, bus_host_oe, address_latch_strobe, device_select_strobe_n,
    output pa_per_o, pa_per_oe, pc_per_o, pc_per_oe, pb_per_o, pb_per_oe
  );
endinterface

// *** src/pioh_pkg.sv ***
// Constants shared by the parallel port device and its processor-side host.
// Assumes both ends run on one clock, hclk, at 50 MHz.
// How it works
// - Latch command word on strobe falling edge
// - Answer only when bits 6-7 match selects
// - Answer only when bits 3-5 are 011
// - Select pulses low twice: read, then write
// - Read pulse drives bus, pulls transfer low
// - Write data taken at second pulse rise
// - Shared line: skip in read, else irq
// - Three-port mode: A4, B12, C4
// - Eight-bit-A mode: C pins become A4-7
// - Handshake mode: A lines become flags, strobes
// - Input strobe latches B, empty flag falls
// - Port B write raises output-full flag
// - Port B driven only while output strobe high
// - Output strobe fall: tristate, full flag low
// - Software starts handshake: full 0, empty 1
// - Each side moves B only when flagged
// - Irq on flag low with enable, handshake only
// - Skips test A11, A9 outside handshake
// - Write makes output, read makes input
// - Power-on: inputs, eight-bit-A mode
// - Mode decode 0x handshake, 10, 11
// - Status read: mode bits, active-low irq bits
// - Empty flag high again after port B read
package pioh_pkg;
  // ****************************************
  // Command word fields
  // ****************************************
  localparam logic [2:0] DEV_PATTERN    = 3'h3;
  localparam int         CS_A_POS       = 6;
  localparam int         CS_B_POS       = 7;
  localparam logic [1:0] PORT_A         = 2'h0;
  localparam logic [1:0] PORT_B         = 2'h1;
  localparam logic [1:0] PORT_C         = 2'h2;
  localparam logic [1:0] OPK_SET        = 2'h0;
  localparam logic [1:0] OPK_CLEAR      = 2'h1;
  localparam logic [1:0] OPK_WRITE      = 2'h2;
  localparam logic [1:0] OPK_READ       = 2'h3;
  localparam logic [3:0] READ_PORT_B_CMD    = 4'h7;
  localparam logic [3:0] SKIP_ON_OUTPUT_CMD = 4'hC;
  localparam logic [3:0] SKIP_ON_INPUT_CMD  = 4'hD;
  localparam logic [3:0] WRITE_STATUS_CMD   = 4'hE;
  localparam logic [3:0] READ_STATUS_CMD    = 4'hF;
  // ****************************************
  // Port A line roles and status bits
  // ****************************************
  localparam int LN_IN_STROBE  = 8;
  localparam int LN_IN_EMPTY   = 9;
  localparam int LN_OUT_STROBE = 10;
  localparam int LN_OUT_FULL   = 11;
  localparam int ST_MODE_HI    = 8;
  localparam int ST_MODE_LO    = 9;
  localparam logic [3:0] HS_DRIVEN_LINES = 4'hA;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic MODE_HI_RST = 1'b1;
  localparam logic MODE_LO_RST = 1'b0;
  localparam logic DIR_RST     = 1'b0;
  // ****************************************
  // Host registers and timing
  // ****************************************
  localparam logic [7:0] HOST_CMD_OFS   = 8'h00;
  localparam logic [7:0] HOST_ACC_OFS   = 8'h04;
  localparam logic [7:0] HOST_STAT_OFS  = 8'h08;
  localparam logic [7:0] HOST_PCTL_OFS  = 8'h0C;
  localparam logic [7:0] HOST_PDATA_OFS = 8'h10;
  localparam logic [7:0] HOST_PIN_OFS   = 8'h14;
  localparam int         CLK_NS         = 20;
  localparam int         T_PHASE_NS     = 200;
  localparam logic [4:0] PHASE_CYC      = 5'((T_PHASE_NS + CLK_NS - 1) / CLK_NS);
endpackage
